// ### pkg/mrt_pkg.sv
// Shared constants and types for the run/trigger coordination logic
package mrt_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int EXEC_PULSE_NS  = 200;
    localparam int TRIG_PULSE_NS  = 200;
    // Minimum pulse times round up to whole cycles
    localparam int EXEC_PULSE_CYC = (EXEC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Echo of our own drive returns through pin and synchroniser
    localparam int ECHO_CYC       = 4;
    localparam int CNT_W          = 6;
    localparam logic [CNT_W-1:0] EXEC_PULSE_CNT = CNT_W'(EXEC_PULSE_CYC);
    localparam logic [CNT_W-1:0] TRIG_PULSE_CNT = CNT_W'(TRIG_PULSE_CYC);
    localparam logic [CNT_W-1:0] TRIG_MASK_CNT  = CNT_W'(TRIG_PULSE_CYC + ECHO_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO       = 6'h00;

    // ------------------------------------------------------------
    // System size, reset values and bit positions
    // ------------------------------------------------------------
    localparam int   MAX_UNITS     = 32;
    localparam logic RDY_PULL_RST  = 1'b1;
    localparam logic EXE_PREV_RST  = 1'b1;
    localparam int   SYNC_BNC      = 2;
    localparam int   SYNC_EXE      = 1;
    localparam int   SYNC_TRIG     = 0;
    localparam int   RUN_BIT       = 2;

    // ------------------------------------------------------------
    // Trigger routing and run state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RT_NONE = 2'h0,
        RT_A    = 2'h1,
        RT_B    = 2'h2
    } mrt_route_type;

    typedef enum logic [2:0] {
        ST_HALT = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } mrt_state_type;

endpackage

// ### pkg/mrt_bus_if.sv
// Coordination bus and trigger connector joining one unit and its peers
`timescale 1ns/1ps
`default_nettype none
interface mrt_bus_if;

    // ------------------------------------------------------------
    // Per-party drive signals
    // ------------------------------------------------------------
    logic dev_trig_out, dev_trig_oe, peer_trig_out, peer_trig_oe;
    logic dev_rdy_out,  dev_rdy_oe,  peer_rdy_out,  peer_rdy_oe;
    logic dev_exe_out,  dev_exe_oe,  peer_exe_out,  peer_exe_oe;
    logic dev_bnc_out,  dev_bnc_oe,  peer_bnc_out,  peer_bnc_oe;

    // ------------------------------------------------------------
    // Resolved line levels
    // ------------------------------------------------------------
    logic trig_n;
    logic ready;
    logic exe_n;
    logic bnc;

    // Bus lines are pulled up and wired-AND; connector is open-emitter OR
    assign trig_n = (~dev_trig_oe | dev_trig_out) & (~peer_trig_oe | peer_trig_out);
    assign ready  = (~dev_rdy_oe  | dev_rdy_out)  & (~peer_rdy_oe  | peer_rdy_out);
    assign exe_n  = (~dev_exe_oe  | dev_exe_out)  & (~peer_exe_oe  | peer_exe_out);
    assign bnc    = (dev_bnc_oe & dev_bnc_out) | (peer_bnc_oe & peer_bnc_out);

    modport dev (
        output dev_trig_out, dev_trig_oe, dev_rdy_out, dev_rdy_oe,
        output dev_exe_out, dev_exe_oe, dev_bnc_out, dev_bnc_oe,
        input  trig_n, ready, exe_n, bnc
    );

    modport peer (
        output peer_trig_out, peer_trig_oe, peer_rdy_out, peer_rdy_oe,
        output peer_exe_out, peer_exe_oe, peer_bnc_out, peer_bnc_oe,
        input  trig_n, ready, exe_n, bnc
    );

endinterface
`default_nettype wire

// ### src/mrt_sync.sv
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module mrt_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ------------------------------------------------------------
    // Per-bit chains
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            // First stage feeds only the second
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d_i[gi];
                    sync_q <= meta_q;
                end
            end
            assign q_o[gi] = sync_q ^ rst_val_i[gi]; // Idle polarity restored
        end
    endgenerate

endmodule
`default_nettype wire

// ### src/mrt_unit.sv
// One emulator unit's logic on the coordination bus and trigger connector
`timescale 1ns/1ps
`default_nettype none
module mrt_unit (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    mrt_bus_if.dev                    bus,
    input  wire logic                 bus_enable_i,
    input  wire logic                 trace_at_exec_i,
    input  wire logic                 in_reset_i,
    input  wire logic                 prepared_i,
    input  wire logic                 run_req_i,
    input  wire logic                 break_req_i,
    input  wire logic                 exec_cmd_i,
    input  wire logic                 ana_trig_a_i,
    input  wire logic                 ana_trig_b_i,
    input  wire mrt_pkg::mrt_route_type bus_drive_sel_i,
    input  wire mrt_pkg::mrt_route_type bus_recv_sel_i,
    input  wire mrt_pkg::mrt_route_type bnc_drive_sel_i,
    input  wire mrt_pkg::mrt_route_type bnc_recv_sel_i,
    input  wire logic                 bus_break_en_i,
    input  wire logic                 bnc_break_en_i,
    input  wire logic                 ext_arm_sel_i,
    output logic                      running_o,
    output logic                      start_at_addr_o,
    output logic                      exec_event_o,
    output logic                      ana_exec_start_o,
    output logic                      trig_break_o,
    output logic                      internal_trigger_a_o,
    output logic                      internal_trigger_b_o,
    output logic                      ext_arm_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mrt_pkg::mrt_state_type     state_q, state_d;
    logic [2:0]                 pins_s;
    logic                       exe_prev_q, bnc_prev_q;
    logic                       exec_raw, exec_emul, bus_lvl, bnc_edge, trig_brk, ready_s;
    logic [mrt_pkg::CNT_W-1:0]  exe_cnt_q, tpulse_cnt_q, tmask_cnt_q;
    logic [2:0]                 bnc_own_q;
    logic                       exec_pend_q, brk_hold_q, rdy_pull_q;
    logic                       bus_trig_drv, bus_trig_drv_q, bnc_drv_q, exe_drv_q;
    logic                       int_a_d, int_b_d, break_now;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // Low-true lines idle high; stored inverted so reset reads idle
    mrt_sync #(
        .WIDTH     (3)
    ) u_sync (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .rst_val_i (3'h3),
        .d_i       ({bus.bnc, ~bus.exe_n, ~bus.trig_n}),
        .q_o       (pins_s)
    );

    // Ready sampled through its own chain, reset reads not ready
    mrt_sync #(
        .WIDTH     (1)
    ) u_sync_rdy (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .rst_val_i (1'h0),
        .d_i       (bus.ready),
        .q_o       (ready_s)
    );

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Execute falls low; bus trigger by level, connector by rising edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            exe_prev_q <= mrt_pkg::EXE_PREV_RST;
            bnc_prev_q <= 1'b0;
        end else begin
            exe_prev_q <= pins_s[mrt_pkg::SYNC_EXE];
            bnc_prev_q <= pins_s[mrt_pkg::SYNC_BNC];
        end
    end

    assign exec_raw  = ~pins_s[mrt_pkg::SYNC_EXE] & exe_prev_q;
    assign exec_emul = exec_raw & bus_enable_i;
    // Own drive and post-execute pulse are masked out
    assign bus_lvl   = ~pins_s[mrt_pkg::SYNC_TRIG] & (tmask_cnt_q == mrt_pkg::CNT_ZERO);
    assign bnc_edge  = pins_s[mrt_pkg::SYNC_BNC] & ~bnc_prev_q & (bnc_own_q == 3'h0);
    assign trig_brk  = (bus_break_en_i & bus_lvl) | (bnc_break_en_i & bnc_edge);

    // ------------------------------------------------------------
    // Trigger line drive and self-echo masking
    // ------------------------------------------------------------
    assign bus_trig_drv = (tpulse_cnt_q != mrt_pkg::CNT_ZERO)
                        | (bus_drive_sel_i == mrt_pkg::RT_A & ana_trig_a_i)
                        | (bus_drive_sel_i == mrt_pkg::RT_B & ana_trig_b_i);

    // Pulse after every execute regardless of routing
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tpulse_cnt_q <= mrt_pkg::CNT_ZERO;
        end else if (exec_raw) begin
            tpulse_cnt_q <= mrt_pkg::TRIG_PULSE_CNT;
        end else if (tpulse_cnt_q != mrt_pkg::CNT_ZERO) begin
            tpulse_cnt_q <= tpulse_cnt_q - 6'h01;
        end
    end

    // Mask reloads while we drive, then covers the echo
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tmask_cnt_q <= mrt_pkg::CNT_ZERO;
        end else if (exec_raw || bus_trig_drv) begin
            tmask_cnt_q <= mrt_pkg::TRIG_MASK_CNT;
        end else if (tmask_cnt_q != mrt_pkg::CNT_ZERO) begin
            tmask_cnt_q <= tmask_cnt_q - 6'h01;
        end
    end

    // Connector drive and history of own drive
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_trig_drv_q <= 1'b0;
            bnc_drv_q      <= 1'b0;
            bnc_own_q      <= 3'h0;
        end else begin
            bus_trig_drv_q <= bus_trig_drv;
            bnc_drv_q      <= (bnc_drive_sel_i == mrt_pkg::RT_A & ana_trig_a_i)
                            | (bnc_drive_sel_i == mrt_pkg::RT_B & ana_trig_b_i);
            bnc_own_q      <= {bnc_own_q[1:0], bnc_drv_q};
        end
    end

    // ------------------------------------------------------------
    // Execute drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            exe_cnt_q <= mrt_pkg::CNT_ZERO;
            exe_drv_q <= 1'b0;
        end else begin
            if (exec_cmd_i) begin
                exe_cnt_q <= mrt_pkg::EXEC_PULSE_CNT;
            end else if (exe_cnt_q != mrt_pkg::CNT_ZERO) begin
                exe_cnt_q <= exe_cnt_q - 6'h01;
            end
            exe_drv_q <= exec_cmd_i | (exe_cnt_q > 6'h01);
        end
    end

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    assign break_now = break_req_i | trig_brk | (bus_enable_i & ~ready_s);

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mrt_pkg::ST_HALT: begin
                if (prepared_i && (run_req_i || exec_pend_q)) begin
                    state_d = mrt_pkg::ST_WAIT;
                end
            end
            mrt_pkg::ST_WAIT: begin
                if (!bus_enable_i || ready_s) begin
                    state_d = mrt_pkg::ST_RUN;
                end
            end
            mrt_pkg::ST_RUN: begin
                if (break_now) begin
                    state_d = mrt_pkg::ST_HALT;
                end
            end
            default: state_d = mrt_pkg::ST_HALT;
        endcase
        if (in_reset_i) begin
            state_d = mrt_pkg::ST_HALT;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= mrt_pkg::ST_HALT;
        end else begin
            state_q <= state_d;
        end
    end

    // Pending execute waits for ready; a new event wins over the clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            exec_pend_q     <= 1'b0;
            start_at_addr_o <= 1'b0;
        end else begin
            start_at_addr_o <= exec_pend_q & (state_q == mrt_pkg::ST_WAIT)
                             & (state_d == mrt_pkg::ST_RUN);
            if (exec_emul) begin
                exec_pend_q <= 1'b1;
            end else if (!bus_enable_i || start_at_addr_o) begin
                exec_pend_q <= 1'b0;
            end
        end
    end

    // Break hold set on leaving run, cleared once resuming
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            brk_hold_q <= 1'b0;
        end else if (state_q == mrt_pkg::ST_RUN && state_d == mrt_pkg::ST_HALT) begin
            brk_hold_q <= 1'b1;
        end else if (state_d == mrt_pkg::ST_WAIT) begin
            brk_hold_q <= 1'b0;
        end
    end

    // Ready pull-down
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdy_pull_q <= mrt_pkg::RDY_PULL_RST;
        end else begin
            rdy_pull_q <= in_reset_i
                        | (bus_enable_i & (~prepared_i | brk_hold_q));
        end
    end

    // ------------------------------------------------------------
    // Internal triggers and event outputs
    // ------------------------------------------------------------
    assign int_a_d = ana_trig_a_i
                   | (bus_recv_sel_i == mrt_pkg::RT_A & bus_lvl)
                   | (bnc_recv_sel_i == mrt_pkg::RT_A & bnc_edge);
    assign int_b_d = ana_trig_b_i
                   | (bus_recv_sel_i == mrt_pkg::RT_B & bus_lvl)
                   | (bnc_recv_sel_i == mrt_pkg::RT_B & bnc_edge);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            internal_trigger_a_o <= 1'b0;
            internal_trigger_b_o <= 1'b0;
            ext_arm_o            <= 1'b0;
            exec_event_o         <= 1'b0;
            ana_exec_start_o     <= 1'b0;
            trig_break_o         <= 1'b0;
        end else begin
            internal_trigger_a_o <= int_a_d;
            internal_trigger_b_o <= int_b_d;
            ext_arm_o            <= ext_arm_sel_i ? int_b_d : int_a_d;
            exec_event_o         <= exec_emul;
            ana_exec_start_o     <= exec_raw & trace_at_exec_i;
            trig_break_o         <= trig_brk;
        end
    end

    // ------------------------------------------------------------
    // Pin drive: bus lines open-drain low, connector drives high
    // ------------------------------------------------------------
    assign bus.dev_trig_out = 1'b0;
    assign bus.dev_trig_oe  = bus_trig_drv_q;
    assign bus.dev_rdy_out  = 1'b0;
    assign bus.dev_rdy_oe   = rdy_pull_q;
    assign bus.dev_exe_out  = 1'b0;
    assign bus.dev_exe_oe   = exe_drv_q;
    assign bus.dev_bnc_out  = 1'b1;
    assign bus.dev_bnc_oe   = bnc_drv_q;
    assign running_o        = state_q[mrt_pkg::RUN_BIT];

endmodule
`default_nettype wire

// ### src/mrt_peer.sv
// Far end of the coordination bus: peer unit or outside instrument
`timescale 1ns/1ps
`default_nettype none
module mrt_peer (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    mrt_bus_if.peer   bus,
    input  wire logic hold_ready_i,
    input  wire logic exec_cmd_i,
    input  wire logic trig_drive_i,
    input  wire logic bnc_drive_i,
    output logic      ready_o,
    output logic      trig_seen_o,
    output logic      exec_seen_o,
    output logic      bnc_rise_o
);

    // ------------------------------------------------------------
    // Synchronised line levels, all active high
    // ------------------------------------------------------------
    logic [3:0]                s;
    logic                      exe_prev_q, bnc_prev_q, exe_drv_q, trig_q, rdy_q, bnc_q;
    logic [mrt_pkg::CNT_W-1:0] exe_cnt_q;

    mrt_sync #(
        .WIDTH     (4)
    ) u_sync (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .rst_val_i (4'h0),
        .d_i       ({bus.ready, bus.bnc, ~bus.exe_n, ~bus.trig_n}),
        .q_o       (s)
    );

    // Drive registers and execute pulse timer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            exe_cnt_q <= mrt_pkg::CNT_ZERO;
            exe_drv_q <= 1'b0;
            trig_q    <= 1'b0;
            rdy_q     <= 1'b0;
            bnc_q     <= 1'b0;
        end else begin
            if (exec_cmd_i) begin
                exe_cnt_q <= mrt_pkg::EXEC_PULSE_CNT;
            end else if (exe_cnt_q != mrt_pkg::CNT_ZERO) begin
                exe_cnt_q <= exe_cnt_q - 6'h01;
            end
            exe_drv_q <= exec_cmd_i | (exe_cnt_q > 6'h01);
            trig_q    <= trig_drive_i;
            rdy_q     <= hold_ready_i;
            bnc_q     <= bnc_drive_i;
        end
    end

    // Observed events; bus trigger is unreliable while execute is used
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            exe_prev_q  <= 1'b0;
            bnc_prev_q  <= 1'b0;
            ready_o     <= 1'b0;
            trig_seen_o <= 1'b0;
            exec_seen_o <= 1'b0;
            bnc_rise_o  <= 1'b0;
        end else begin
            exe_prev_q  <= s[1];
            bnc_prev_q  <= s[2];
            ready_o     <= s[3];
            trig_seen_o <= s[0];
            exec_seen_o <= s[1] & ~exe_prev_q;
            bnc_rise_o  <= s[2] & ~bnc_prev_q;
        end
    end

    // Open-drain bus lines, open-emitter connector
    assign bus.peer_trig_out = 1'b0;
    assign bus.peer_trig_oe  = trig_q;
    assign bus.peer_rdy_out  = 1'b0;
    assign bus.peer_rdy_oe   = rdy_q;
    assign bus.peer_exe_out  = 1'b0;
    assign bus.peer_exe_oe   = exe_drv_q;
    assign bus.peer_bnc_out  = 1'b1;
    assign bus.peer_bnc_oe   = bnc_q;

endmodule
`default_nettype wire

// ### verif/mrt_props.sv
// Concurrent checks on the coordination bus lines between unit and peer
`timescale 1ns/1ps
`default_nettype none
module mrt_props (
    input wire logic mclk_i, rst_i, trig_n, exe_n, ready, bnc,
    input wire logic dev_trig_out, dev_trig_oe, dev_rdy_out, dev_rdy_oe,
    input wire logic dev_exe_out, dev_exe_oe, dev_bnc_out, dev_bnc_oe,
    input wire logic peer_rdy_oe, peer_exe_oe
);
    // -------------------------------------------------------------
    // Line checks, all in the one clock domain
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_ready_in_reset: assert property ($fell(rst_i) |-> dev_rdy_oe)
        else $error("ready not pulled low through reset");
    chk_idle_after_reset: assert property ($fell(rst_i) |->
        !dev_trig_oe && !dev_exe_oe && !dev_bnc_oe && !peer_rdy_oe && !peer_exe_oe)
        else $error("a line was driven straight out of reset");
    // Own drive must really pull the shared line to its active level
    chk_trig_low_true: assert property (dev_trig_oe |-> !dev_trig_out && !trig_n)
        else $error("bus trigger not pulled low");
    chk_ready_open_drain: assert property (dev_rdy_oe |-> !dev_rdy_out && !ready)
        else $error("ready not pulled low");
    chk_exec_low_true: assert property (dev_exe_oe |-> !dev_exe_out && !exe_n)
        else $error("execute not pulled low");
    chk_bnc_high_drive: assert property (dev_bnc_oe |-> dev_bnc_out && bnc)
        else $error("connector not driven high");
    chk_peer_exec_len: assert property ($rose(peer_exe_oe) |->
        ##24 peer_exe_oe ##1 !peer_exe_oe)
        else $error("peer execute pulse length wrong");
    chk_dev_exec_len: assert property ($rose(dev_exe_oe) |->
        ##24 dev_exe_oe ##1 !dev_exe_oe)
        else $error("unit execute pulse length wrong");
    // Two sync edges, the detect edge, then the registered drive
    chk_trig_after_exec: assert property ($fell(exe_n) |-> ##4 $rose(dev_trig_oe)
        ##24 dev_trig_oe ##1 !dev_trig_oe)
        else $error("no trigger pulse after execute");
    // Main scenarios reached
    cov_exec: cover property ($fell(exe_n));
    cov_ready: cover property ($rose(ready));
    cov_bnc: cover property ($rose(bnc));
    cov_trig: cover property ($fell(trig_n));
endmodule
`default_nettype wire

// ### verif/test_multi_unit_run_trigger_sync.sv
// Self-checking bench joining one unit and one peer over the coordination bus
`timescale 1ns/1ps
`default_nettype none
module test_multi_unit_run_trigger_sync;
    logic mclk_i = 0, rst_i = 1;
    logic bus_enable_i = 1, trace_at_exec_i = 0, in_reset_i = 1, prepared_i = 1;
    logic run_req_i = 0, break_req_i = 0, exec_cmd_i = 0, ana_trig_a_i = 0, ana_trig_b_i = 0;
    mrt_pkg::mrt_route_type bus_drive_sel_i = mrt_pkg::RT_NONE, bus_recv_sel_i = mrt_pkg::RT_A;
    mrt_pkg::mrt_route_type bnc_drive_sel_i = mrt_pkg::RT_NONE, bnc_recv_sel_i = mrt_pkg::RT_B;
    logic bus_break_en_i = 0, bnc_break_en_i = 0, ext_arm_sel_i = 0;
    logic running_o, start_at_addr_o, exec_event_o, ana_exec_start_o, trig_break_o;
    logic internal_trigger_a_o, internal_trigger_b_o, ext_arm_o, p_ready;
    logic p_hold = 0, p_exec = 0, p_trig = 0, p_bnc = 0, p_trig_seen, p_exec_seen, p_bnc_rise;
    int n_errors = 0, n_checks = 0, cyc = 0, k = 0;
    int c_exec = 0, c_ana = 0, c_brk = 0, c_start = 0, c_ptrig = 0, c_pexec = 0, c_prise = 0;
    mrt_bus_if bus ();
    mrt_unit mrt_unit_i (.*);
    mrt_peer mrt_peer_i (.mclk_i, .rst_i, .bus, .hold_ready_i(p_hold), .exec_cmd_i(p_exec),
        .trig_drive_i(p_trig), .bnc_drive_i(p_bnc), .ready_o(p_ready), .trig_seen_o(p_trig_seen),
        .exec_seen_o(p_exec_seen), .bnc_rise_o(p_bnc_rise));
    mrt_props mrt_props_i (.mclk_i, .rst_i, .trig_n(bus.trig_n), .exe_n(bus.exe_n),
        .ready(bus.ready), .bnc(bus.bnc), .dev_trig_out(bus.dev_trig_out),
        .dev_trig_oe(bus.dev_trig_oe), .dev_rdy_out(bus.dev_rdy_out), .dev_rdy_oe(bus.dev_rdy_oe),
        .dev_exe_out(bus.dev_exe_out), .dev_exe_oe(bus.dev_exe_oe),
        .dev_bnc_out(bus.dev_bnc_out), .dev_bnc_oe(bus.dev_bnc_oe),
        .peer_rdy_oe(bus.peer_rdy_oe), .peer_exe_oe(bus.peer_exe_oe));
    // Clock of 8 ns
    initial forever #4 mclk_i = ~mclk_i;
    // Pulse counters and hang limit
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        c_exec <= c_exec + exec_event_o;
        c_ana <= c_ana + ana_exec_start_o;
        c_brk <= c_brk + trig_break_o;
        c_start <= c_start + start_at_addr_o;
        c_ptrig <= c_ptrig + p_trig_seen;
        c_pexec <= c_pexec + p_exec_seen;
        c_prise <= c_prise + p_bnc_rise;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    initial begin
        tick(2);
        check(bus.ready, 0);
        tick(1);
        rst_i = 0;
        tick(4);
        check(bus.ready, 0);
        in_reset_i = 0;
        tick(4);
        check(bus.ready, 1);
        check(p_ready, 1);
        pulse(run_req_i);
        tick(8);
        check(running_o, 1);
        p_hold = 1;
        tick(6);
        check(running_o, 0);
        p_hold = 0;
        tick(6);
        check(bus.ready, 0);
        pulse(run_req_i);
        tick(10);
        check(running_o, 1);
        bus_break_en_i = 1;
        for (int i = 0; i < 2; i++) begin
            trace_at_exec_i = i[0];
            k = c_start;
            pulse(break_req_i);
            tick(4);
            check(running_o, 0);
            pulse(p_exec);
            tick(40);
            check(8'(c_exec), 8'(i + 1));
            check(8'(c_ana), 8'(i));
            check(8'(c_start - k), 1);
            check(running_o, 1);
        end
        check(8'(c_brk), 0);
        check(c_ptrig != 0, 1);
        // Bus trigger is ignored until the post-execute mask runs out
        tick(18);
        p_trig = 1;
        tick(6);
        check(running_o, 0);
        check(bus.ready, 0);
        check(internal_trigger_a_o, 1);
        check(ext_arm_o, 1);
        p_trig = 0;
        bus_break_en_i = 0;
        bnc_break_en_i = 1;
        // Let the last level break pulse be counted before the snapshot
        tick(2);
        k = c_brk;
        p_bnc = 1;
        tick(12);
        p_bnc = 0;
        tick(4);
        check(8'(c_brk - k), 1);
        bnc_break_en_i = 0;
        bnc_drive_sel_i = mrt_pkg::RT_B;
        ana_trig_b_i = 1;
        k = c_prise;
        tick(6);
        check(8'(c_prise - k), 1);
        check(internal_trigger_b_o, 1);
        ana_trig_b_i = 0;
        bus_drive_sel_i = mrt_pkg::RT_A;
        ana_trig_a_i = 1;
        tick(4);
        check(bus.trig_n, 0);
        check(p_trig_seen, 1);
        ana_trig_a_i = 0;
        bus_drive_sel_i = mrt_pkg::RT_NONE;
        bus_enable_i = 0;
        p_hold = 1;
        tick(6);
        pulse(run_req_i);
        tick(8);
        check(running_o, 1);
        k = c_exec;
        pulse(p_exec);
        tick(8);
        check(8'(c_exec - k), 0);
        p_hold = 0;
        bus_enable_i = 1;
        // Execute must be released again before the next event
        tick(30);
        k = c_pexec;
        pulse(exec_cmd_i);
        tick(40);
        check(8'(c_pexec - k), 1);
        close_out();
    end
endmodule
`default_nettype wire
